//--- rtl/wdt_top.v
`include "wdt_regs.vh"

module wdt_top #(
    parameter TICK_DIV = `WDT_TICK_CYCLES
) (
    input wire CLK,
    input wire RESETN,
    input wire [1:0] MODE_CONFIG,
    input wire SLEEP,
    input wire CLEAR_INSTR,
    input wire OSC_FAIL,
    input wire WAKE,
    input wire CRYSTAL_CLOCK,
    input wire OST_RUNNING,
    input wire DIVIDER_CHANGE,
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    output reg RESET_REQ,
    output reg WAKE_REQ,
    output reg TIMEOUT_FLAG_N,
    output reg POWERDOWN_FLAG_N,
    output wire IRQ
);
    // ****************************************
    // bus slave
    // ****************************************
    // one wait state per access, so the answer is registered
    reg ack_q;
    reg en_q;
    reg [4:0] ps_q;
    reg [1:0] st_q;
    reg [1:0] mask_q;
    wire req;
    wire wr;
    wire [7:0] ctrl;

    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign wr = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
    assign ctrl = {2'h0, ps_q, en_q};

    function is_reg;
        input [3:0] a;
        input [3:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_q <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            if (AVS_READ & ~ack_q) begin
                if (is_reg(AVS_ADDRESS, `WDT_OFS_CONTROL))
                    AVS_READDATA <= {24'h000000, ctrl};
                else if (is_reg(AVS_ADDRESS, `WDT_OFS_STATUS))
                    AVS_READDATA <= {30'h00000000, st_q};
                else if (is_reg(AVS_ADDRESS, `WDT_OFS_IRQ_MASK))
                    AVS_READDATA <= {30'h00000000, mask_q};
                else
                    AVS_READDATA <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_q <= 1'b0;
            ps_q <= `WDT_PS_RESET;
            mask_q <= 2'h0;
        end else if (wr && is_reg(AVS_ADDRESS, `WDT_OFS_CONTROL)) begin
            en_q <= AVS_WRITEDATA[`WDT_EN_BIT];
            ps_q <= AVS_WRITEDATA[`WDT_PS_MSB:`WDT_PS_LSB];
        end else if (wr && is_reg(AVS_ADDRESS, `WDT_OFS_IRQ_MASK)) begin
            mask_q <= AVS_WRITEDATA[1:0];
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    reg active;
    always @* begin
        case (MODE_CONFIG)
            `WDT_MODE_ON: active = 1'b1;
            `WDT_MODE_NOSLEEP: active = ~SLEEP;
            `WDT_MODE_SW: active = en_q;
            `WDT_MODE_OFF: active = 1'b0;
            default: active = 1'b0;
        endcase
    end

    // ****************************************
    // counter and clearing
    // ****************************************
    reg sleep_q;
    wire sleep_edge;
    wire hold_ost;
    wire clear;
    wire tick;
    wire expire;

    assign sleep_edge = SLEEP ^ sleep_q;
    // crystal clocks keep the count parked until start-up completes
    assign hold_ost = CRYSTAL_CLOCK & OST_RUNNING & ~SLEEP;
    // divider changes are deliberately not a clear source
    assign clear = CLEAR_INSTR | sleep_edge | WAKE | OSC_FAIL | ~active | hold_ost;

    wdt_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(CLK),
        .resetn(RESETN),
        .tick(tick)
    );

    wdt_prescale #(
        .W(28)
    ) u_pre (
        .clk(CLK),
        .resetn(RESETN),
        .tick(tick),
        .clear(clear),
        .period(ps_q),
        .expire(expire),
        .count()
    );

    // ****************************************
    // outcome of an expiry
    // ****************************************
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sleep_q <= 1'b0;
            RESET_REQ <= 1'b0;
            WAKE_REQ <= 1'b0;
            TIMEOUT_FLAG_N <= 1'b1;
            POWERDOWN_FLAG_N <= 1'b1;
            st_q <= 2'h0;
        end else begin
            sleep_q <= SLEEP;
            RESET_REQ <= expire & ~SLEEP;
            WAKE_REQ <= expire & SLEEP;
            if (expire) begin
                TIMEOUT_FLAG_N <= 1'b0;
                POWERDOWN_FLAG_N <= ~SLEEP;
            end else if (CLEAR_INSTR) begin
                TIMEOUT_FLAG_N <= 1'b1;
                POWERDOWN_FLAG_N <= 1'b1;
            end else if (SLEEP & ~sleep_q) begin
                POWERDOWN_FLAG_N <= 1'b0;
            end
            // set beats write-one-clear
            st_q[`WDT_ST_AWAKE_TO] <= (expire & ~SLEEP) | (st_q[`WDT_ST_AWAKE_TO] &
                ~(wr & is_reg(AVS_ADDRESS, `WDT_OFS_STATUS) & AVS_WRITEDATA[0]));
            st_q[`WDT_ST_SLEEP_TO] <= (expire & SLEEP) | (st_q[`WDT_ST_SLEEP_TO] &
                ~(wr & is_reg(AVS_ADDRESS, `WDT_OFS_STATUS) & AVS_WRITEDATA[1]));
        end
    end

    assign IRQ = |(st_q & mask_q);
endmodule // wdt_top

//--- rtl/wdt_regs.vh
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// Behaviour
// - awake expiry without clear request resets the device
// - counter ticks from 31 kHz oscillator
// - mode 11 keeps watchdog always active
// - mode 10 active awake, off asleep
// - mode 01 follows software enable bit
// - mode 00 off; enable ignored then
// - software enable write turns watchdog on/off in mode 01 only
// - period code selects prescale 32 shl code
// - reserved period codes act as minimum
// - period select resets to code 01011
// - clear on reset, instruction, sleep, failure, disable
// - crystal wake holds clear until startup done
// - divider change leaves counter untouched
// - counting resumes in sleep when enabled
// - sleep expiry wakes and updates status flags
// - control bits 7-6 zero, 5-1 period, 0 enable

// ****************************************
// register map
// ****************************************
`define WDT_OFS_CONTROL 4'h0
`define WDT_OFS_STATUS 4'h4
`define WDT_OFS_IRQ_MASK 4'h8

// ****************************************
// fields and reset values
// ****************************************
`define WDT_EN_BIT 0
`define WDT_PS_LSB 1
`define WDT_PS_MSB 5
`define WDT_PS_RESET 5'h0B
`define WDT_PS_MAX 5'h12
`define WDT_PS_MIN 5'h00
`define WDT_BASE_LOG2 5
`define WDT_ST_AWAKE_TO 0
`define WDT_ST_SLEEP_TO 1

// ****************************************
// modes
// ****************************************
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SW 2'h1
`define WDT_MODE_NOSLEEP 2'h2
`define WDT_MODE_ON 2'h3

// ****************************************
// timing
// ****************************************
`define WDT_CLK_HZ 100000000
`define WDT_LF_HZ 31000
`define WDT_TICK_CYCLES (`WDT_CLK_HZ / `WDT_LF_HZ)
`endif

//--- rtl/wdt_tick.v
`include "wdt_regs.vh"

// low frequency time base: one pulse per nominal 31 kHz period
module wdt_tick #(
    parameter DIV = `WDT_TICK_CYCLES
) (
    input wire clk,
    input wire resetn,
    output reg tick
);
    reg [15:0] cnt_q;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_q == DIV[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // wdt_tick

//--- rtl/wdt_prescale.v
`include "wdt_regs.vh"

// ripple of the time base; expiry when bit (4+code) is about to wrap
module wdt_prescale #(
    parameter W = 28
) (
    input wire clk,
    input wire resetn,
    input wire tick,
    input wire clear,
    input wire [4:0] period,
    output wire expire,
    output wire [W-1:0] count
);
    reg [W-1:0] cnt_q;
    wire [4:0] eff;
    wire [W-1:0] limit;

    // reserved codes fall back to the shortest interval
    assign eff = (period > `WDT_PS_MAX) ? `WDT_PS_MIN : period;
    assign limit = ({{(W-1){1'b0}}, 1'b1} << (eff + `WDT_BASE_LOG2))
        - {{(W-1){1'b0}}, 1'b1};
    // low bits only, so a count left above a freshly shortened period still expires
    assign expire = tick && !clear && ((cnt_q & limit) == limit);
    assign count = cnt_q;

    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            cnt_q <= {W{1'b0}};
        else if (clear || expire)
            cnt_q <= {W{1'b0}};
        else if (tick)
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
endmodule // wdt_prescale

//--- testbench/wdt_top_props.sv
module wdt_top_props (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [1:0] MODE_CONFIG,
    input wire logic SLEEP,
    input wire logic CLEAR_INSTR,
    input wire logic OSC_FAIL,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic RESET_REQ,
    input wire logic WAKE_REQ,
    input wire logic TIMEOUT_FLAG_N,
    input wire logic POWERDOWN_FLAG_N
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // checks
    // ****
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    chk_reset_one: assert property (RESET_REQ |=> !RESET_REQ)
        else $error("reset request held");
    chk_wake_one: assert property (WAKE_REQ |=> !WAKE_REQ)
        else $error("wake request held");
    chk_sleep_noreset: assert property (SLEEP && $past(SLEEP) |-> !RESET_REQ)
        else $error("reset in sleep");
    chk_off_quiet: assert property (MODE_CONFIG == 2'h0 && $past(MODE_CONFIG) == 2'h0
        |-> !(RESET_REQ || WAKE_REQ)) else $error("expiry while off");
    chk_nosleep_off: assert property (MODE_CONFIG == 2'h2 && SLEEP && $past(SLEEP)
        |-> !WAKE_REQ) else $error("wake in mode 10");
    chk_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("wait state count");
    chk_clear_quiet: assert property (CLEAR_INSTR
        |-> ##2 (!RESET_REQ && !WAKE_REQ) [*8]) else $error("expiry after clear");
    chk_fail_quiet: assert property (OSC_FAIL [*2] |=> !(RESET_REQ || WAKE_REQ))
        else $error("expiry in osc fail");
    chk_flag_wake: assert property (WAKE_REQ
        |-> ##[0:1] (!TIMEOUT_FLAG_N && !POWERDOWN_FLAG_N)) else $error("flags after wake");
    cover property (RESET_REQ);
    cover property (WAKE_REQ);
    cover property (OSC_FAIL [*2]);
endmodule // wdt_top_props

bind wdt_top wdt_top_props i_wdt_top_props (.CLK(CLK), .RESETN(RESETN),
    .MODE_CONFIG(MODE_CONFIG), .SLEEP(SLEEP), .CLEAR_INSTR(CLEAR_INSTR),
    .OSC_FAIL(OSC_FAIL), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RESET_REQ(RESET_REQ), .WAKE_REQ(WAKE_REQ),
    .TIMEOUT_FLAG_N(TIMEOUT_FLAG_N), .POWERDOWN_FLAG_N(POWERDOWN_FLAG_N));

//--- testbench/wdt_top_tb.sv
module wdt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [1:0] MODE_CONFIG = 2'h1;
    logic SLEEP = 1'b0, CLEAR_INSTR = 1'b0, OSC_FAIL = 1'b0, WAKE = 1'b0;
    logic CRYSTAL_CLOCK = 1'b0, OST_RUNNING = 1'b0, DIVIDER_CHANGE = 1'b0;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic AVS_WAITREQUEST, RESET_REQ, WAKE_REQ, TIMEOUT_FLAG_N, POWERDOWN_FLAG_N, IRQ;
    int fail_count = 0, checks_done = 0, n, i;
    // reserved codes must time out like code 0
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};
    int spans [5] = '{8, 16, 32, 8, 8};

    // short time base keeps code 0 near 64 cycles
    wdt_top #(.TICK_DIV(2)) i_wdt_top (.CLK(CLK), .RESETN(RESETN),
        .MODE_CONFIG(MODE_CONFIG), .SLEEP(SLEEP), .CLEAR_INSTR(CLEAR_INSTR),
        .OSC_FAIL(OSC_FAIL), .WAKE(WAKE), .CRYSTAL_CLOCK(CRYSTAL_CLOCK),
        .OST_RUNNING(OST_RUNNING), .DIVIDER_CHANGE(DIVIDER_CHANGE),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .RESET_REQ(RESET_REQ), .WAKE_REQ(WAKE_REQ), .TIMEOUT_FLAG_N(TIMEOUT_FLAG_N),
        .POWERDOWN_FLAG_N(POWERDOWN_FLAG_N), .IRQ(IRQ));

    initial forever #5 CLK = ~CLK;

    // divider setting keeps moving under every interval measurement
    initial forever begin
        repeat (24) @(posedge CLK);
        DIVIDER_CHANGE <= !DIVIDER_CHANGE;
    end

    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    // cycles to the next expiry pulse, capped at lim
    task automatic pulse(input int lim);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (!(RESET_REQ || WAKE_REQ) && n < lim);
    endtask

    task automatic ins(input logic [1:0] m, input logic s);
        @(posedge CLK);
        MODE_CONFIG <= m;
        SLEEP <= s;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk("control", 32'h16, q);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 4'h0, 32'hFF);
        bus(1'b0, 4'h0, 32'h0);
        chk("control", 32'h3F, q);
        $display("test register done");
        for (i = 0; i < 5; i++) begin
            bus(1'b1, 4'h0, {26'h0, codes[i], 1'b1});
            pulse(2000);
            pulse(2000);
            chk("interval", spans[i], (n + 4) >> 3);
            chk("pulse", 32'h2, {RESET_REQ, WAKE_REQ});
        end
        chk("to flag", 32'h0, TIMEOUT_FLAG_N);
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h8, 32'h3);
        bus(1'b0, 4'h4, 32'h0);
        chk("status", 32'h1, q);
        chk("irq", 32'h1, IRQ);
        bus(1'b1, 4'h4, 32'h3);
        bus(1'b0, 4'h4, 32'h0);
        chk("status", 32'h0, q);
        chk("irq", 32'h0, IRQ);
        pulse(1000);
        chk("sw off", 1000, n);
        $display("test period done");
        bus(1'b1, 4'h0, 32'h1);
        ins(2'h0, 1'b0);
        pulse(1000);
        chk("mode off", 1000, n);
        bus(1'b1, 4'h0, 32'h0);
        ins(2'h2, 1'b0);
        pulse(2000);
        pulse(2000);
        chk("awake", 8, (n + 4) >> 3);
        ins(2'h2, 1'b1);
        pulse(1000);
        chk("sleep off", 1000, n);
        ins(2'h3, 1'b1);
        CLEAR_INSTR <= 1'b1;
        @(posedge CLK);
        CLEAR_INSTR <= 1'b0;
        pulse(2000);
        pulse(2000);
        chk("sleep", 8, (n + 4) >> 3);
        chk("wake", 32'h1, {RESET_REQ, WAKE_REQ});
        @(negedge CLK);
        chk("flags", 32'h0, {TIMEOUT_FLAG_N, POWERDOWN_FLAG_N});
        $display("test modes done");
        @(posedge CLK);
        CRYSTAL_CLOCK <= 1'b1;
        OST_RUNNING <= 1'b1;
        SLEEP <= 1'b0;
        WAKE <= 1'b1;
        @(posedge CLK);
        WAKE <= 1'b0;
        pulse(1000);
        chk("ost hold", 1000, n);
        @(posedge CLK);
        OST_RUNNING <= 1'b0;
        pulse(2000);
        chk("after ost", 8, (n + 4) >> 3);
        n = 0;
        for (i = 0; i < 400; i++) begin
            @(posedge CLK);
            CLEAR_INSTR <= (i % 40 == 0);
            @(negedge CLK);
            if (RESET_REQ === 1'b1)
                n++;
        end
        chk("cleared", 0, n);
        @(posedge CLK);
        OSC_FAIL <= 1'b1;
        pulse(1000);
        chk("osc fail", 1000, n);
        $display("test clear done");
        finish_test;
    end

    // whole run is near 7000 cycles
    initial begin
        #500000;
        fail_count++;
        finish_test;
    end
endmodule // wdt_top_tb
